// [common/mogc_consts.vh]
// Constants for the mixer and output gain control register slice.
// Assumes a 10 MHz clock and a 32-bit APB register port.
`ifndef MOGC_CONSTS_VH
`define MOGC_CONSTS_VH

// ==================================================================
// Register indices (byte address is four times the index)
`define MOGC_IDX_MIC 8'h07
`define MOGC_IDX_MONO 8'h08
`define MOGC_IDX_DAC1 8'h09
`define MOGC_IDX_DAC2 8'h0A
`define MOGC_IDX_CTRL 8'h10

// ==================================================================
// Reset values
`define MOGC_RST_MIC 16'h8888
`define MOGC_RST_MONO 16'h8868
`define MOGC_RST_DAC 16'h8888
`define MOGC_RST_CTRL 16'h0000

// ==================================================================
// Write masks; reserved bits stay zero
`define MOGC_WMASK_MIX 16'h9F9F
`define MOGC_WMASK_MONO 16'h9FFB
`define MOGC_WMASK_DAC 16'hBFBF
`define MOGC_WMASK_CTRL 16'h001F
`define MOGC_WMASK_RDY 16'h0003

// ==================================================================
// Mono/misc field positions
`define MOGC_MONO_MUTE 15
`define MOGC_MONO_GAIN_HI 12
`define MOGC_MONO_GAIN_LO 8
`define MOGC_ALL_MIX_MUTE 7
`define MOGC_MONO_OUT_MUTE 6
`define MOGC_HP_MUTE 5
`define MOGC_HP_SWING 4
`define MOGC_SUM_MUTE 3
`define MOGC_DAC2_TIMING 1
`define MOGC_DAC1_TIMING 0

// ==================================================================
// Mic register right-channel gain field
`define MOGC_RMIC_GAIN_HI 4
`define MOGC_RMIC_GAIN_LO 0

// ==================================================================
// DAC gain register fields
`define MOGC_DAC_LMUTE 15
`define MOGC_DAC_LGAIN_HI 13
`define MOGC_DAC_LGAIN_LO 8
`define MOGC_DAC_RMUTE 7
`define MOGC_DAC_RGAIN_HI 5
`define MOGC_DAC_RGAIN_LO 0

// ==================================================================
// Control register bits
`define MOGC_CTL_CONV_OFF 0
`define MOGC_CTL_MIX_EN 1
`define MOGC_CTL_ANA_EN 2
`define MOGC_CTL_DAC1_EN 3
`define MOGC_CTL_DAC2_EN 4

// ==================================================================
// Deferred update time-out, 10 to 12 ms window; pick 11 ms
`define MOGC_TIMEOUT_US 11000
`define MOGC_CLK_MHZ 10

`endif

// [src/mogc_gain_defer.v]
// Deferred gain update for one DAC pair.
// Assumes the zero-crossing strobe is synchronous to clock.
`timescale 1ns/1ps
module mogc_gain_defer #(
    parameter TIMEOUT_CYCLES = 110000,
    parameter CW = 17
) (
    input wire clock,
    input wire arst_n,
    input wire forceDefault,
    input wire [15:0] defaultValue,
    input wire [15:0] pendingValue,
    input wire newWrite,
    input wire immediate,
    input wire zeroCross,
    output reg [15:0] appliedValue,
    output wire pending
);

    reg pending_q;
    reg [CW-1:0] count_q;
    wire timeUp;

    assign pending = pending_q;
    assign timeUp = (count_q == TIMEOUT_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

    // ==============================================================
    // Apply at once, or on midscale crossing or time-out
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            appliedValue <= 16'h8888;
            pending_q <= 1'b0;
            count_q <= {CW{1'b0}};
        end else if (forceDefault) begin
            appliedValue <= defaultValue;
            pending_q <= 1'b0;
            count_q <= {CW{1'b0}};
        end else if (immediate) begin
            appliedValue <= pendingValue; // see RL10 see RL11
            pending_q <= 1'b0;
            count_q <= {CW{1'b0}};
        end else if (newWrite) begin
            pending_q <= 1'b1; // Restart time-out on rewrite, see RL21
            count_q <= {CW{1'b0}};
        end else if (pending_q && (zeroCross || timeUp)) begin
            appliedValue <= pendingValue; // see RL10 see RL11
            pending_q <= 1'b0;
            count_q <= {CW{1'b0}};
        end else if (pending_q) begin
            count_q <= count_q + {{(CW-1){1'b0}}, 1'b1}; // see RL21
        end
    end

endmodule

// [src/mogc_mixer_gain_ctrl.v]
// Mixer and output gain control registers behind an APB slave.
// Assumes reset and power-down pins are asynchronous to clock.
//
// Functional notes
// RL1: Right mic mix gain is five bits, 1.5 dB steps, code 8 is 0 dB.
// RL2: Mic mix register resets to 8888 hex, locked when mix or analog disabled.
// RL3: Mono mix gain five bits for both channels, 1.5 dB per step.
// RL4: Mono mix mute at bit 15 mutes the mono input mix.
// RL5: All-mix mute silences every mix path into DAC1, overriding others; the code overrides only the mic and mono mix mutes, not summing.
// RL6: Mono output mute bit silences the mono output.
// RL7: One headphone mute bit silences both headphone outputs.
// RL8: Headphone swing bit selects 2 V or 4 V peak-to-peak.
// RL9: Summing mute bit silences summing pin mix into DAC1.
// RL10: DAC2 timing bit: immediate, else wait for midscale or time-out.
// RL11: DAC1 timing bit: immediate, else wait for midscale or time-out.
// RL12: Mono/misc register resets to 8868 hex.
// RL13: Mono/misc locked at default on reset, power-down or conversions off.
// RL14: Mono/misc upper byte also locked when mix or analog disabled.
// RL15: Each DAC1 channel has its own analog mute bit.
// RL16: Each DAC2 channel has its own analog mute bit.
// RL17: Six-bit DAC gain: top bit clear analog only, set adds digital.
// RL18: DAC1 gain resets 8888 hex, locked when analog or DAC1 disabled.
// RL19: Software writes zero to every reserved bit.
// RL20: DAC2 gain resets 8888 hex, locked when analog or DAC2 disabled.
// RL21: Time-out counts device clocks and restarts on each pending rewrite.
`timescale 1ns/1ps
`include "mogc_consts.vh"
module mogc_mixer_gain_ctrl #(
    parameter TIMEOUT_CYCLES = `MOGC_TIMEOUT_US * `MOGC_CLK_MHZ
) (
    input wire clock,
    input wire arst_n,
    input wire powerDownPin_n,
    input wire [31:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire dac1ZeroCross,
    input wire dac2ZeroCross,
    output reg [4:0] rightMicMixGain,
    output reg rightMicMixMute,
    output reg [4:0] monoInMixGain,
    output reg monoInMixMute,
    output reg allMixToDac1Mute,
    output reg monoOutMute,
    output reg headphoneOutMute,
    output reg headphoneSwingSelect,
    output reg summingInputMute,
    output reg leftDac1AnalogMute,
    output reg [5:0] leftDac1Gain,
    output reg rightDac1AnalogMute,
    output reg [5:0] rightDac1Gain,
    output reg leftDac2AnalogMute,
    output reg [5:0] leftDac2Gain,
    output reg rightDac2AnalogMute,
    output reg [5:0] rightDac2Gain
);

    // ==============================================================
    // Signals
    reg pdSync1_q;
    reg pdSync2_q;
    reg [15:0] mic_q;
    reg [15:0] mono_q;
    reg [15:0] dac1_q;
    reg [15:0] dac2_q;
    reg [15:0] ctrl_q;
    reg [31:0] prdata_d;
    wire [15:0] dac1Applied;
    wire [15:0] dac2Applied;
    wire dac1Pending;
    wire dac2Pending;
    wire [7:0] regIndex;
    wire wrAccess;
    wire wrLow;
    wire wrHigh;
    wire addrValid;
    wire conversionsOff;
    wire globalClear;
    wire mixLock;
    wire dac1Lock;
    wire dac2Lock;
    wire [15:0] wdata16;
    wire wrMic;
    wire wrMono;
    wire wrDac1;
    wire wrDac2;
    wire wrCtrl;
    wire [15:0] byteMask;
    wire [15:0] monoDefault;
    wire [15:0] monoMask;

    // Full-width copies so each byte lane is selected, not truncated
    assign monoDefault = `MOGC_RST_MONO;
    assign monoMask = `MOGC_WMASK_MONO;

    // ==============================================================
    // Power-down pin passes two flops; arrives from outside
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pdSync1_q <= 1'b0;
            pdSync2_q <= 1'b0;
        end else begin
            pdSync1_q <= powerDownPin_n;
            pdSync2_q <= pdSync1_q;
        end
    end

    // ==============================================================
    // APB decode; zero-wait slave, word aligned
    assign regIndex = paddr[9:2];
    assign addrValid = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000) &&
                       (regIndex == `MOGC_IDX_MIC || regIndex == `MOGC_IDX_MONO ||
                        regIndex == `MOGC_IDX_DAC1 || regIndex == `MOGC_IDX_DAC2 ||
                        regIndex == `MOGC_IDX_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addrValid;
    assign wrAccess = psel & penable & pwrite & addrValid;
    assign wrLow = pstrb[0];
    assign wrHigh = pstrb[1];
    assign byteMask = {{8{wrHigh}}, {8{wrLow}}};
    assign wdata16 = pwdata[15:0];
    assign wrMic = wrAccess && regIndex == `MOGC_IDX_MIC;
    assign wrMono = wrAccess && regIndex == `MOGC_IDX_MONO;
    assign wrDac1 = wrAccess && regIndex == `MOGC_IDX_DAC1;
    assign wrDac2 = wrAccess && regIndex == `MOGC_IDX_DAC2;
    assign wrCtrl = wrAccess && regIndex == `MOGC_IDX_CTRL;

    // ==============================================================
    // Clear-and-lock conditions
    assign conversionsOff = ctrl_q[`MOGC_CTL_CONV_OFF];
    assign globalClear = ~pdSync2_q | conversionsOff; // see RL13
    assign mixLock = globalClear | ~ctrl_q[`MOGC_CTL_MIX_EN] |
                     ~ctrl_q[`MOGC_CTL_ANA_EN]; // see RL2 see RL14
    assign dac1Lock = globalClear | ~ctrl_q[`MOGC_CTL_ANA_EN] |
                      ~ctrl_q[`MOGC_CTL_DAC1_EN]; // see RL18
    assign dac2Lock = globalClear | ~ctrl_q[`MOGC_CTL_ANA_EN] |
                      ~ctrl_q[`MOGC_CTL_DAC2_EN]; // see RL20

    // ==============================================================
    // Enable register; powers on with mix, analog and both DACs disabled, conversions-off bit clear
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `MOGC_RST_CTRL;
        end else if (wrCtrl) begin
            ctrl_q <= (ctrl_q & ~(byteMask & `MOGC_WMASK_CTRL)) |
                      (wdata16 & byteMask & `MOGC_WMASK_CTRL);
        end
    end

    // ==============================================================
    // Mic mix register; reserved bits never stored
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mic_q <= `MOGC_RST_MIC;
        end else if (mixLock) begin
            mic_q <= `MOGC_RST_MIC; // see RL2
        end else if (wrMic) begin
            mic_q <= (mic_q & ~(byteMask & `MOGC_WMASK_MIX)) |
                     (wdata16 & byteMask & `MOGC_WMASK_MIX); // see RL1
        end
    end

    // ==============================================================
    // Mono/misc register; upper byte has the stricter lock
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mono_q <= `MOGC_RST_MONO; // see RL12
        end else if (globalClear) begin
            mono_q <= `MOGC_RST_MONO; // see RL13
        end else begin
            if (mixLock) begin
                mono_q[15:8] <= monoDefault[15:8]; // see RL14
            end else if (wrMono && wrHigh) begin
                mono_q[15:8] <= wdata16[15:8] & monoMask[15:8]; // see RL3
            end
            if (wrMono && wrLow) begin
                mono_q[7:0] <= wdata16[7:0] & monoMask[7:0];
            end
        end
    end

    // ==============================================================
    // DAC gain shadow registers; applied values come from defer units
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dac1_q <= `MOGC_RST_DAC;
            dac2_q <= `MOGC_RST_DAC;
        end else begin
            if (dac1Lock) begin
                dac1_q <= `MOGC_RST_DAC; // see RL18
            end else if (wrDac1) begin
                dac1_q <= (dac1_q & ~(byteMask & `MOGC_WMASK_DAC)) |
                          (wdata16 & byteMask & `MOGC_WMASK_DAC);
            end
            if (dac2Lock) begin
                dac2_q <= `MOGC_RST_DAC; // see RL20
            end else if (wrDac2) begin
                dac2_q <= (dac2_q & ~(byteMask & `MOGC_WMASK_DAC)) |
                          (wdata16 & byteMask & `MOGC_WMASK_DAC);
            end
        end
    end

    // ==============================================================
    // Click-free update units, one per DAC pair
    mogc_gain_defer #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
        .CW(17)
    ) uDac1Defer (
        .clock(clock),
        .arst_n(arst_n),
        .forceDefault(dac1Lock),
        .defaultValue(`MOGC_RST_DAC),
        .pendingValue(dac1_q),
        .newWrite(wrDac1),
        .immediate(mono_q[`MOGC_DAC1_TIMING]),
        .zeroCross(dac1ZeroCross),
        .appliedValue(dac1Applied),
        .pending(dac1Pending)
    );

    mogc_gain_defer #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
        .CW(17)
    ) uDac2Defer (
        .clock(clock),
        .arst_n(arst_n),
        .forceDefault(dac2Lock),
        .defaultValue(`MOGC_RST_DAC),
        .pendingValue(dac2_q),
        .newWrite(wrDac2),
        .immediate(mono_q[`MOGC_DAC2_TIMING]),
        .zeroCross(dac2ZeroCross),
        .appliedValue(dac2Applied),
        .pending(dac2Pending)
    );

    // ==============================================================
    // Read mux; index 16 also reports pending updates in bits 9:8
    always @* begin
        prdata_d = 32'h00000000;
        case (regIndex)
            `MOGC_IDX_MIC: prdata_d = {16'h0000, mic_q};
            `MOGC_IDX_MONO: prdata_d = {16'h0000, mono_q};
            `MOGC_IDX_DAC1: prdata_d = {16'h0000, dac1_q};
            `MOGC_IDX_DAC2: prdata_d = {16'h0000, dac2_q};
            `MOGC_IDX_CTRL: prdata_d = {22'h000000, dac2Pending, dac1Pending, 3'b000,
                                        ctrl_q[4:0]};
            default: prdata_d = 32'h00000000;
        endcase
    end

    // Read data registered in setup so it stands in the access phase
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_d;
        end
    end

    // ==============================================================
    // Output drives; all-mix mute overrides the mic and mono mix mutes into DAC1
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rightMicMixGain <= 5'h08;
            rightMicMixMute <= 1'b1;
            monoInMixGain <= 5'h08;
            monoInMixMute <= 1'b1;
            allMixToDac1Mute <= 1'b0;
            monoOutMute <= 1'b1;
            headphoneOutMute <= 1'b1;
            headphoneSwingSelect <= 1'b0;
            summingInputMute <= 1'b1;
            leftDac1AnalogMute <= 1'b1;
            leftDac1Gain <= 6'h08;
            rightDac1AnalogMute <= 1'b1;
            rightDac1Gain <= 6'h08;
            leftDac2AnalogMute <= 1'b1;
            leftDac2Gain <= 6'h08;
            rightDac2AnalogMute <= 1'b1;
            rightDac2Gain <= 6'h08;
        end else begin
            rightMicMixGain <= mic_q[`MOGC_RMIC_GAIN_HI:`MOGC_RMIC_GAIN_LO]; // see RL1
            rightMicMixMute <= mic_q[`MOGC_DAC_RMUTE] | mono_q[`MOGC_ALL_MIX_MUTE]; // see RL5
            monoInMixGain <= mono_q[`MOGC_MONO_GAIN_HI:`MOGC_MONO_GAIN_LO]; // see RL3
            monoInMixMute <= mono_q[`MOGC_MONO_MUTE] | mono_q[`MOGC_ALL_MIX_MUTE]; // see RL4
            allMixToDac1Mute <= mono_q[`MOGC_ALL_MIX_MUTE]; // see RL5
            monoOutMute <= mono_q[`MOGC_MONO_OUT_MUTE]; // see RL6
            headphoneOutMute <= mono_q[`MOGC_HP_MUTE]; // see RL7
            headphoneSwingSelect <= mono_q[`MOGC_HP_SWING]; // see RL8
            summingInputMute <= mono_q[`MOGC_SUM_MUTE]; // see RL9
            leftDac1AnalogMute <= dac1Applied[`MOGC_DAC_LMUTE]; // see RL15
            leftDac1Gain <= dac1Applied[`MOGC_DAC_LGAIN_HI:`MOGC_DAC_LGAIN_LO]; // see RL17
            rightDac1AnalogMute <= dac1Applied[`MOGC_DAC_RMUTE]; // see RL15
            rightDac1Gain <= dac1Applied[`MOGC_DAC_RGAIN_HI:`MOGC_DAC_RGAIN_LO];
            leftDac2AnalogMute <= dac2Applied[`MOGC_DAC_LMUTE]; // see RL16
            leftDac2Gain <= dac2Applied[`MOGC_DAC_LGAIN_HI:`MOGC_DAC_LGAIN_LO];
            rightDac2AnalogMute <= dac2Applied[`MOGC_DAC_RMUTE]; // see RL16
            rightDac2Gain <= dac2Applied[`MOGC_DAC_RGAIN_HI:`MOGC_DAC_RGAIN_LO];
        end
    end

endmodule

// [verif/mogc_mixer_gain_monitor.sv]
// Checker for the mixer and output gain control slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module mogc_mixer_gain_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic powerDownPin_n,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] rightMicMixGain,
    input wire logic rightMicMixMute,
    input wire logic monoInMixMute,
    input wire logic allMixToDac1Mute,
    input wire logic monoOutMute,
    input wire logic headphoneOutMute,
    input wire logic headphoneSwingSelect,
    input wire logic summingInputMute,
    input wire logic leftDac1AnalogMute,
    input wire logic [5:0] leftDac1Gain,
    input wire logic rightDac2AnalogMute,
    input wire logic [5:0] rightDac2Gain
);
    // ==============================================================
    // Clocking and decode
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // Mapped byte addresses of the slice
    wire logic mapped = paddr == 32'h1C || paddr == 32'h20 || paddr == 32'h24
        || paddr == 32'h28 || paddr == 32'h40;

    // ==============================================================
    // Assertions
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_addr_error: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_err_rdata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_allmix_over: assert property (allMixToDac1Mute |-> rightMicMixMute && monoInMixMute)
        else $error("all-mix mute not applied to mix paths");
    // Six cycles cover the two-flop pin sync plus register and output stages
    a_pd_mono: assert property ((!powerDownPin_n)[*6] |-> monoOutMute && headphoneOutMute
        && summingInputMute && monoInMixMute && !allMixToDac1Mute && !headphoneSwingSelect)
        else $error("mono register not at default in power-down");
    a_pd_dac: assert property ((!powerDownPin_n)[*6] |-> leftDac1Gain == 6'h08
        && leftDac1AnalogMute && rightDac2Gain == 6'h08 && rightDac2AnalogMute)
        else $error("DAC gain not at default in power-down");
    a_reset_out: assert property ($rose(arst_n) |-> rightMicMixGain == 5'h08
        && rightMicMixMute && headphoneOutMute && leftDac1Gain == 6'h08)
        else $error("outputs not at default after reset");
endmodule

bind mogc_mixer_gain_ctrl mogc_mixer_gain_monitor i_mon (
    .clock(clock), .arst_n(arst_n), .powerDownPin_n(powerDownPin_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rightMicMixGain(rightMicMixGain), .rightMicMixMute(rightMicMixMute),
    .monoInMixMute(monoInMixMute), .allMixToDac1Mute(allMixToDac1Mute),
    .monoOutMute(monoOutMute), .headphoneOutMute(headphoneOutMute),
    .headphoneSwingSelect(headphoneSwingSelect), .summingInputMute(summingInputMute),
    .leftDac1AnalogMute(leftDac1AnalogMute), .leftDac1Gain(leftDac1Gain),
    .rightDac2AnalogMute(rightDac2AnalogMute), .rightDac2Gain(rightDac2Gain)
);

// [verif/tb_top.sv]
// Self-checking bench for the mixer and output gain control slice.
// Assumes the short time-out parameter and an APB master driven here.
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic arst_n, powerDownPin_n, psel, penable, pwrite, dac1ZeroCross, dac2ZeroCross, erv;
    logic [31:0] paddr, pwdata, rdv;
    logic [3:0] pstrb;
    wire [31:0] prdata;
    wire pready, pslverr, rMicMute, monoMute, allMix, monoOut, hpMute, hpSwing, sumMute;
    wire l1Mute, r1Mute, l2Mute, r2Mute;
    wire [4:0] rMicGain, monoGain;
    wire [5:0] l1Gain, r1Gain, l2Gain, r2Gain;
    wire [4:0] miscOut = {allMix, monoOut, hpMute, hpSwing, sumMute};
    integer err_total = 0, num_checks = 0, cycles = 0, i;
    // Address, write data, read-back, error flag
    logic [40:0] rows [0:6] = '{{8'h1C, 16'hFFFF, 16'h9F9F, 1'b0},
        {8'h20, 16'hFFFF, 16'h9FFB, 1'b0}, {8'h24, 16'hFFFF, 16'hBFBF, 1'b0},
        {8'h28, 16'h4141, 16'h0101, 1'b0}, {8'h40, 16'h001E, 16'h001E, 1'b0},
        {8'h2C, 16'h1234, 16'h0000, 1'b1}, {8'h00, 16'h1234, 16'h0000, 1'b1}};
    logic [5:0] codes [0:4] = '{6'h00, 6'h08, 6'h1F, 6'h20, 6'h3F};

    // ==============================================================
    // Design and clock
    mogc_mixer_gain_ctrl #(.TIMEOUT_CYCLES(20)) i_dut (
        .clock(clock), .arst_n(arst_n), .powerDownPin_n(powerDownPin_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac1ZeroCross(dac1ZeroCross),
        .dac2ZeroCross(dac2ZeroCross), .rightMicMixGain(rMicGain), .rightMicMixMute(rMicMute),
        .monoInMixGain(monoGain), .monoInMixMute(monoMute), .allMixToDac1Mute(allMix),
        .monoOutMute(monoOut), .headphoneOutMute(hpMute), .headphoneSwingSelect(hpSwing),
        .summingInputMute(sumMute), .leftDac1AnalogMute(l1Mute), .leftDac1Gain(l1Gain),
        .rightDac1AnalogMute(r1Mute), .rightDac1Gain(r1Gain), .leftDac2AnalogMute(l2Mute),
        .leftDac2Gain(l2Gain), .rightDac2AnalogMute(r2Mute), .rightDac2Gain(r2Gain));
    // Free-running 100 ns clock
    always #50 clock = ~clock;

    // ==============================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total = err_total + 1;
        end
    endtask
    // One transfer, request held until pready is sampled high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wt(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulse(input logic second);
        if (second) dac2ZeroCross <= 1'b1;
        else dac1ZeroCross <= 1'b1;
        @(posedge clock);
        dac1ZeroCross <= 1'b0;
        dac2ZeroCross <= 1'b0;
        wt(2);
    endtask
    task end_of_test;
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard; the whole sequence needs well under 1000 cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    // ==============================================================
    // Main sequence
    initial begin
        {arst_n, psel, penable, pwrite, dac1ZeroCross, dac2ZeroCross} = 6'h00;
        {paddr, pwdata} = 64'h0;
        powerDownPin_n = 1'b1;
        pstrb = 4'hF;
        wt(6);
        arst_n <= 1'b1;
        wt(3);
        rd(32'h1C);
        chk("mic reset", 32'h8888, rdv);
        rd(32'h20);
        chk("mono reset", 32'h8868, rdv);
        rd(32'h24);
        chk("dac1 reset", 32'h8888, rdv);
        rd(32'h28);
        chk("dac2 reset", 32'h8888, rdv);
        chk("misc reset", 32'h0D, miscOut);
        $display("Test reset done");
        wr(32'h40, 32'h1E);
        for (i = 0; i < 7; i = i + 1) begin
            wr({24'h0, rows[i][40:33]}, {16'h0, rows[i][32:17]});
            rd({24'h0, rows[i][40:33]});
            chk("row read", {16'h0, rows[i][16:1]}, rdv);
            chk("row error", {31'h0, rows[i][0]}, {31'h0, erv});
        end
        $display("Test rows done");
        for (i = 0; i < 5; i = i + 1) begin
            wr(32'h1C, {27'h0, codes[i][4:0]});
            wr(32'h20, {19'h0, codes[i][4:0], 8'h03});
            wr(32'h24, {18'h0, codes[i], 8'h00});
            wt(2);
            chk("mic gain", {27'h0, codes[i][4:0]}, rMicGain);
            chk("mono gain", {27'h0, codes[i][4:0]}, monoGain);
            chk("dac1 gain", {26'h0, codes[i]}, l1Gain);
            chk("mic mute", 32'h0, rMicMute);
        end
        $display("Test gains done");
        for (i = 3; i < 8; i = i + 1) begin
            wr(32'h20, (32'h1 << i) | 32'h3);
            wt(2);
            chk("misc bits", 32'h1 << (i - 3), miscOut);
        end
        chk("mic under all-mix", 32'h1, rMicMute);
        wr(32'h20, 32'h8003);
        wr(32'h24, 32'h0080);
        wr(32'h28, 32'h8000);
        wt(2);
        chk("mono mix mute", 32'h1, monoMute);
        chk("dac mutes", 32'h6, {l1Mute, r1Mute, l2Mute, r2Mute});
        $display("Test mutes done");
        wr(32'h20, 32'h0002);
        wr(32'h24, 32'h1010);
        wt(3);
        chk("dac1 held", 32'h0, l1Gain);
        pulse(1'b0);
        chk("dac1 on crossing", 32'h10, l1Gain);
        wr(32'h24, 32'h2020);
        wt(14);
        wr(32'h24, 32'h3030);
        wt(14);
        chk("dac1 restart", 32'h10, l1Gain);
        wt(10);
        chk("dac1 time-out", 32'h30, l1Gain);
        chk("dac1 right time-out", 32'h30, r1Gain);
        wr(32'h28, 32'h0505);
        wt(2);
        chk("dac2 immediate", 32'h05, r2Gain);
        chk("dac2 left immediate", 32'h05, l2Gain);
        wr(32'h20, 32'h0000);
        wr(32'h28, 32'h0707);
        pulse(1'b0);
        chk("dac2 held", 32'h05, r2Gain);
        pulse(1'b1);
        chk("dac2 on crossing", 32'h07, r2Gain);
        pstrb <= 4'h1;
        wr(32'h1C, 32'h9F03);
        pstrb <= 4'hF;
        rd(32'h1C);
        chk("mic byte strobe", 32'h0003, rdv);
        $display("Test deferral done");
        wr(32'h40, 32'h1F);
        wr(32'h20, 32'h0000);
        rd(32'h20);
        chk("mono conv off", 32'h8868, rdv);
        wr(32'h40, 32'h18);
        wr(32'h20, 32'h0000);
        rd(32'h20);
        chk("mono upper lock", 32'h8800, rdv);
        rd(32'h1C);
        chk("mic lock", 32'h8888, rdv);
        wr(32'h40, 32'h16);
        wr(32'h24, 32'h0000);
        rd(32'h24);
        chk("dac1 lock", 32'h8888, rdv);
        wr(32'h40, 32'h0E);
        wr(32'h28, 32'h0000);
        rd(32'h28);
        chk("dac2 lock", 32'h8888, rdv);
        wr(32'h40, 32'h1E);
        wr(32'h20, 32'h0000);
        powerDownPin_n <= 1'b0;
        wt(8);
        rd(32'h20);
        chk("mono power-down", 32'h8868, rdv);
        powerDownPin_n <= 1'b1;
        wt(3);
        $display("Test locks done");
        end_of_test();
    end
endmodule
